//--- core/tmmo_regs.vh
// constants for the tracker matrix, distortion score and tip offset command block
`ifndef TMMO_REGS_VH
`define TMMO_REGS_VH
// command bytes
`define TMMO_CMD_MATRIX 8'h58
`define TMMO_CMD_DIST 8'h73
`define TMMO_CMD_OFFSET 8'h4B
// distortion option selectors
`define TMMO_SEL_OFF 8'h00
`define TMMO_SEL_ON 8'h01
`define TMMO_SEL_SENS 8'h02
`define TMMO_SEL_OFFS 8'h03
`define TMMO_SEL_SLOPE 8'h04
`define TMMO_SEL_ALPHA 8'h05
// power-up defaults and limits
`define TMMO_DEF_SENS 7'h20
`define TMMO_DEF_ALPHA 7'h0C
`define TMMO_DEF_OFFS 8'h00
`define TMMO_DEF_SLOPE 8'h00
`define TMMO_ALPHA_MAX 7'h7F
`define TMMO_SCORE_MAX 7'h7F
// record layout
`define TMMO_MATRIX_BYTES 5'd18
`define TMMO_OFFSET_BYTES 3'd6
`define TMMO_SYNC_BIT 7
`endif

//--- core/tmmo_score.v
// distortion score computation and smoothing filter
`timescale 1ns/1ps
`default_nettype none
`include "tmmo_regs.vh"
module tmmo_score
(
   // clock and reset
   input wire mclk,
   input wire rst_b,
   // settings
   input wire [6:0] sens,
   input wire signed [7:0] offs,
   input wire signed [7:0] slope,
   input wire [6:0] alpha,
   // measurement
   input wire sample_valid,
   input wire signed [15:0] raw_system_error,
   input wire [15:0] range,
   // result
   output reg [6:0] field_distortion_score
);
   // score = sens * (raw - (offs + slope * range))
   wire signed [24:0] slope_term = slope * $signed({1'b0, range});
   wire signed [25:0] base = $signed({{18{offs[7]}}, offs}) + slope_term;
   wire signed [26:0] diff = raw_system_error - base;
   wire signed [34:0] prod = diff * $signed({1'b0, sens});
   // clamp to 0..127; negative error means better than baseline
   wire [6:0] inst = prod[34] ? 7'h00 :
      (prod > 35'sd127) ? `TMMO_SCORE_MAX : prod[6:0];
   // first-order filter: alpha 127 tracks, 0 holds
   wire signed [8:0] delta = $signed({2'b00, inst}) - $signed({2'b00, field_distortion_score});
   wire signed [16:0] step = delta * $signed({1'b0, alpha});
   wire [6:0] next_score = (alpha == `TMMO_ALPHA_MAX) ? inst :
      field_distortion_score + step[13:7];
   always @(posedge mclk)
   begin
      if (!rst_b)
         field_distortion_score <= 7'h00;
      else if (sample_valid)
         field_distortion_score <= next_score;
   end
endmodule // tmmo_score
`default_nettype wire

//--- core/tmmo_cmd.v
// command interpreter: matrix output, distortion scoring, tip offset
// ==========================================================
`timescale 1ns/1ps
`default_nettype none
`include "tmmo_regs.vh"
module tmmo_cmd
(
   // clock and reset
   input wire mclk,
   input wire rst_b,
   // host command bytes (same clock)
   input wire rx_valid,
   input wire [7:0] rx_byte,
   // record request and measurement data
   input wire record_req,
   input wire offset_read_req,
   input wire [143:0] matrix_in,
   input wire button_mode,
   input wire [7:0] button_byte,
   input wire sample_valid,
   input wire signed [15:0] raw_system_error,
   input wire [15:0] range,
   // sensor-frame position and rotated offset supplied by pose engine
   input wire signed [15:0] pos_x_in,
   input wire signed [15:0] pos_y_in,
   input wire signed [15:0] pos_z_in,
   input wire signed [15:0] rot_off_x,
   input wire signed [15:0] rot_off_y,
   input wire signed [15:0] rot_off_z,
   // returned bytes
   input wire tx_ready,
   output reg tx_valid,
   output reg [7:0] tx_byte,
   // status
   output reg matrix_mode,
   output reg dist_enable,
   output reg [15:0] offset_x,
   output reg [15:0] offset_y,
   output reg [15:0] offset_z,
   output reg [15:0] pos_x,
   output reg [15:0] pos_y,
   output reg [15:0] pos_z,
   output reg busy
);
   // ==========================================================
   // command parser
   localparam P_IDLE = 2'd0;
   localparam P_DIST = 2'd1;
   localparam P_OFFS = 2'd2;
   reg [1:0] pstate;
   reg [2:0] pcount;
   reg [7:0] sel_hold;
   reg [39:0] offs_hold;
   reg [6:0] sens;
   reg [7:0] offs;
   reg [7:0] slope;
   reg [6:0] alpha;
   always @(posedge mclk)
   begin
      if (!rst_b)
      begin
         pstate <= P_IDLE;
         pcount <= 3'd0;
         sel_hold <= 8'h00;
         offs_hold <= 40'h0;
         matrix_mode <= 1'b0;
         dist_enable <= 1'b0;
         sens <= `TMMO_DEF_SENS;
         offs <= `TMMO_DEF_OFFS;
         slope <= `TMMO_DEF_SLOPE;
         alpha <= `TMMO_DEF_ALPHA;
         offset_x <= 16'h0000;
         offset_y <= 16'h0000;
         offset_z <= 16'h0000;
      end
      else if (rx_valid)
      begin
         case (pstate)
            P_IDLE:
            begin
               pcount <= 3'd0;
               if (rx_byte == `TMMO_CMD_MATRIX)
                  matrix_mode <= 1'b1;
               else if (rx_byte == `TMMO_CMD_DIST)
                  pstate <= P_DIST;
               else if (rx_byte == `TMMO_CMD_OFFSET)
                  pstate <= P_OFFS;
               else
                  matrix_mode <= 1'b0;
            end
            P_DIST:
            begin
               // selector first, value applied only on the second byte
               if (pcount == 3'd0)
               begin
                  sel_hold <= rx_byte;
                  pcount <= 3'd1;
               end
               else
               begin
                  pstate <= P_IDLE;
                  pcount <= 3'd0;
                  case (sel_hold)
                     `TMMO_SEL_OFF: dist_enable <= 1'b0;
                     `TMMO_SEL_ON:
                     begin
                        dist_enable <= 1'b1;
                        sens <= `TMMO_DEF_SENS;
                        offs <= `TMMO_DEF_OFFS;
                        slope <= `TMMO_DEF_SLOPE;
                        alpha <= `TMMO_DEF_ALPHA;
                     end
                     `TMMO_SEL_SENS:
                     begin
                        dist_enable <= 1'b1;
                        sens <= rx_byte[6:0];
                     end
                     `TMMO_SEL_OFFS:
                     begin
                        dist_enable <= 1'b1;
                        offs <= rx_byte;
                     end
                     `TMMO_SEL_SLOPE:
                     begin
                        dist_enable <= 1'b1;
                        slope <= rx_byte;
                     end
                     `TMMO_SEL_ALPHA:
                     begin
                        dist_enable <= 1'b1;
                        alpha <= rx_byte[6:0];
                     end
                     default: dist_enable <= dist_enable;
                  endcase
               end
            end
            P_OFFS:
            begin
               if (pcount == 3'd5)
               begin
                  // all six bytes in: apply together, low byte first
                  offset_x <= {offs_hold[31:24], offs_hold[39:32]};
                  offset_y <= {offs_hold[15:8], offs_hold[23:16]};
                  offset_z <= {rx_byte, offs_hold[7:0]};
                  pstate <= P_IDLE;
                  pcount <= 3'd0;
               end
               else
               begin
                  offs_hold <= {offs_hold[31:0], rx_byte};
                  pcount <= pcount + 3'd1;
               end
            end
            default: pstate <= P_IDLE;
         endcase
      end
   end
   // ==========================================================
   // score engine
   wire [6:0] score;
   tmmo_score u_score
   (
      .mclk(mclk),
      .rst_b(rst_b),
      .sens(sens),
      .offs(offs),
      .slope(slope),
      .alpha(alpha),
      .sample_valid(sample_valid),
      .raw_system_error(raw_system_error),
      .range(range),
      .field_distortion_score(score)
   );
   // ==========================================================
   // offset applied to position; wraps like the pose words
   always @(posedge mclk)
   begin
      if (!rst_b)
      begin
         pos_x <= 16'h0000;
         pos_y <= 16'h0000;
         pos_z <= 16'h0000;
      end
      else
      begin
         pos_x <= pos_x_in + rot_off_x;
         pos_y <= pos_y_in + rot_off_y;
         pos_z <= pos_z_in + rot_off_z;
      end
   end
   // ==========================================================
   // record transmitter
   localparam T_IDLE = 2'd0;
   localparam T_MAT = 2'd1;
   localparam T_OFF = 2'd2;
   localparam T_TAIL = 2'd3;
   reg [1:0] tstate;
   reg [4:0] tidx;
   reg [143:0] mat_snap;
   reg [47:0] off_snap;
   reg send_button;
   reg send_score;
   reg [7:0] next_byte;
   wire [15:0] cur_elem = mat_snap[143 - 16 * tidx[4:1] -: 16];
   wire [15:0] cur_off = off_snap[47 - 16 * tidx[2:1] -: 16];
   wire take = !tx_valid || tx_ready;
   always @*
   begin
      next_byte = 8'h00;
      if (tstate == T_MAT)
      begin
         if (tidx[0])
            next_byte = {1'b0, cur_elem[15:9]};
         else
            next_byte = {(tidx == 5'd0), cur_elem[8:2]};
      end
      else if (tstate == T_OFF)
         next_byte = tidx[0] ? cur_off[15:8] : cur_off[7:0];
      else if (tstate == T_TAIL)
         next_byte = send_button ? button_byte : {1'b0, score};
   end
   always @(posedge mclk)
   begin
      if (!rst_b)
      begin
         tstate <= T_IDLE;
         tidx <= 5'd0;
         mat_snap <= 144'h0;
         off_snap <= 48'h0;
         send_button <= 1'b0;
         send_score <= 1'b0;
         tx_valid <= 1'b0;
         tx_byte <= 8'h00;
         busy <= 1'b0;
      end
      else
      begin
         if (tx_valid && tx_ready)
            tx_valid <= 1'b0;
         case (tstate)
            T_IDLE:
            begin
               tidx <= 5'd0;
               if (offset_read_req)
               begin
                  off_snap <= {offset_x, offset_y, offset_z};
                  tstate <= T_OFF;
                  busy <= 1'b1;
               end
               else if (record_req && matrix_mode)
               begin
                  // elements ordered M11 M21 M31 M12 ... M33, 16-bit fractions
                  mat_snap <= matrix_in;
                  send_button <= button_mode;
                  send_score <= dist_enable;
                  tstate <= T_MAT;
                  busy <= 1'b1;
               end
            end
            T_MAT:
               if (take)
               begin
                  tx_valid <= 1'b1;
                  tx_byte <= next_byte;
                  tidx <= tidx + 5'd1;
                  if (tidx == `TMMO_MATRIX_BYTES - 5'd1)
                  begin
                     if (send_button || send_score)
                        tstate <= T_TAIL;
                     else
                     begin
                        tstate <= T_IDLE;
                        busy <= 1'b0;
                     end
                  end
               end
            T_OFF:
               if (take)
               begin
                  tx_valid <= 1'b1;
                  tx_byte <= next_byte;
                  tidx <= tidx + 5'd1;
                  if (tidx == {2'b00, `TMMO_OFFSET_BYTES} - 5'd1)
                  begin
                     tstate <= T_IDLE;
                     busy <= 1'b0;
                  end
               end
            T_TAIL:
               if (take)
               begin
                  tx_valid <= 1'b1;
                  tx_byte <= next_byte;
                  if (send_button)
                  begin
                     send_button <= 1'b0;
                     if (!send_score)
                     begin
                        tstate <= T_IDLE;
                        busy <= 1'b0;
                     end
                  end
                  else
                  begin
                     send_score <= 1'b0;
                     tstate <= T_IDLE;
                     busy <= 1'b0;
                  end
               end
            default: tstate <= T_IDLE;
         endcase
      end
   end
endmodule // tmmo_cmd
`default_nettype wire

//--- test/tmmo_checker.sv
// port assertions for the command block
`timescale 1ns/1ps
`default_nettype none
`include "tmmo_regs.vh"
module tmmo_checker (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // inputs
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   input wire logic record_req,
   input wire logic offset_read_req,
   input wire logic button_mode,
   input wire logic tx_ready,
   input wire logic signed [15:0] pos_x_in,
   input wire logic signed [15:0] rot_off_x,
   // outputs
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte,
   input wire logic matrix_mode,
   input wire logic dist_enable,
   input wire logic busy,
   input wire logic [15:0] offset_z,
   input wire logic [15:0] pos_x
);
   logic [4:0] nb;
   logic [2:0] rem;
   logic [7:0] cmd;
   logic [7:0] sel;
   logic rd_off;
   // readback bytes carry no sync bit, so keep them out of the record checks
   always_ff @(posedge mclk)
      if (!rst_b)
         rd_off <= 1'b0;
      else if (!busy && (offset_read_req || (record_req && matrix_mode)))
         rd_off <= offset_read_req;
   // bytes handed over in the current record
   always_ff @(posedge mclk)
      if (!rst_b || (!busy && !tx_valid))
         nb <= 5'h0;
      else if (tx_valid && tx_ready)
         nb <= nb + 5'h1;
   // shadow parser so data bytes are never mistaken for commands
   always_ff @(posedge mclk)
      if (!rst_b)
         rem <= 3'h0;
      else if (rx_valid)
      begin
         if (rem == 3'h0)
         begin
            cmd <= rx_byte;
            rem <= (rx_byte == `TMMO_CMD_DIST) ? 3'h2 :
               (rx_byte == `TMMO_CMD_OFFSET) ? 3'h6 : 3'h0;
         end
         else
            rem <= rem - 3'h1;
         if (rem == 3'h2)
            sel <= rx_byte;
      end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   tx_hold_a: assert property (
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
      else $error("tx byte changed before ready");
   rec_start_a: assert property (
      record_req && matrix_mode && !busy && !tx_valid && !offset_read_req
      |-> ##2 tx_valid && tx_byte[7])
      else $error("record start late or unmarked");
   sync_low_a: assert property (
      tx_valid && matrix_mode && !rd_off && nb != 5'h0 && nb < 5'd18 |-> !tx_byte[7])
      else $error("bit 7 set past first byte");
   rec_len_a: assert property (
      tx_valid && matrix_mode && !rd_off |-> nb < 5'd18 + button_mode + dist_enable)
      else $error("record too long");
   mat_cmd_a: assert property (
      rx_valid && rem == 3'h0 && rx_byte == `TMMO_CMD_MATRIX |=> matrix_mode)
      else $error("matrix mode not entered");
   dist_sel_a: assert property (
      rx_valid && rem == 3'h1 && cmd == `TMMO_CMD_DIST && sel < 8'h06
      |=> dist_enable == (sel != 8'h00))
      else $error("scoring enable wrong");
   off_load_a: assert property (
      rx_valid && rem == 3'h1 && cmd == `TMMO_CMD_OFFSET
      |=> offset_z[15:8] == $past(rx_byte))
      else $error("offset high byte not loaded");
   partial_a: assert property (
      cmd == `TMMO_CMD_OFFSET && rem != 3'h0 && !(rx_valid && rem == 3'h1)
      |=> $stable(offset_z))
      else $error("offset changed early");
   pos_sum_a: assert property (
      $past(rst_b) |-> pos_x == $past(pos_x_in) + $past(rot_off_x))
      else $error("position not offset");
endmodule // tmmo_checker
`default_nettype wire

//--- test/tmmo_host.sv
// host model: sends command bytes and drains returned bytes
`timescale 1ns/1ps
`default_nettype none
module tmmo_host (
   // clock
   input wire logic mclk,
   // command bytes
   output logic rx_valid,
   output logic [7:0] rx_byte,
   // returned bytes
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte,
   output logic tx_ready
);
   logic slow = 1'b0;
   logic [7:0] got [$];
   initial
   begin
      rx_valid = 1'b0;
      rx_byte = 8'h00;
      tx_ready = 1'b1;
   end
   // slow host drops ready every other cycle
   always @(posedge mclk)
   begin
      if (tx_valid && tx_ready)
         got.push_back(tx_byte);
      #1 tx_ready = slow ? !tx_ready : 1'b1;
   end
   // released line shows the complement, not a stale byte
   task send(input logic [7:0] b);
      @(posedge mclk);
      #1 rx_valid = 1'b1;
      rx_byte = b;
      @(posedge mclk);
      #1 rx_valid = 1'b0;
      rx_byte = ~b;
   endtask
endmodule // tmmo_host
`default_nettype wire

//--- test/tb_tracker_matrix_metal_offset_cmds.sv
// testbench for the matrix, score and tip offset commands
`timescale 1ns/1ps
`default_nettype none
module tb_tracker_matrix_metal_offset_cmds;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic record_req = 1'b0;
   logic offset_read_req = 1'b0;
   logic button_mode = 1'b0;
   logic sample_valid = 1'b0;
   logic [15:0] raw = 16'h0032;
   logic [15:0] rng = 16'h0000;
   logic [15:0] px = 16'h0064, py = 16'h0000, pz = 16'h0000;
   logic [15:0] ox = 16'h1333, oy = 16'h0000, oz = 16'h0000;
   logic [7:0] btn = 8'hA5;
   logic [143:0] mat = 144'h7FFF_8000_0000_1234_ABCD_0004_FFFC_5A5A_0201;
   logic rx_valid, tx_valid, tx_ready, matrix_mode, dist_enable, busy;
   logic [7:0] rx_byte, tx_byte;
   logic [15:0] offset_x, offset_y, offset_z, pos_x, pos_y, pos_z;
   int n_fail = 0;
   int tests_run = 0;
   always #12.5 mclk = ~mclk;
   tmmo_host host (.mclk, .rx_valid, .rx_byte, .tx_valid, .tx_byte, .tx_ready);
   tmmo_cmd uut (.mclk, .rst_b, .rx_valid, .rx_byte, .record_req, .offset_read_req,
      .matrix_in(mat), .button_mode, .button_byte(btn), .sample_valid,
      .raw_system_error(raw), .range(rng), .pos_x_in(px), .pos_y_in(py),
      .pos_z_in(pz), .rot_off_x(ox), .rot_off_y(oy), .rot_off_z(oz),
      .tx_ready, .tx_valid, .tx_byte, .matrix_mode, .dist_enable, .offset_x,
      .offset_y, .offset_z, .pos_x, .pos_y, .pos_z, .busy);
   task chk(input string s, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      end
   endtask
   task test_done;
      if (n_fail == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task cmd3(input logic [7:0] a, b, c);
      host.send(a);
      host.send(b);
      host.send(c);
   endtask
   task req(input logic rd, input int n);
      int i;
      host.got.delete();
      @(posedge mclk);
      #1 record_req = !rd;
      offset_read_req = rd;
      @(posedge mclk);
      #1 record_req = 1'b0;
      offset_read_req = 1'b0;
      for (i = 0; i < 200 && (busy || tx_valid || host.got.size() < n); i++)
         cyc(1);
      if (i == 200)
      begin
         n_fail++;
         test_done();
      end
      cyc(4);
      chk("len", n[15:0], 16'(host.got.size()));
   endtask
   task score(input logic [7:0] s, v, e);
      cmd3(8'h73, s, v);
      cyc(2);
      sample_valid = 1'b1;
      cyc(1);
      sample_valid = 1'b0;
      cyc(4);
      host.send(8'h58);
      req(1'b0, 20);
      chk("btn", btn, host.got[18]);
      chk("score", e, host.got[19]);
   endtask
   task t_matrix;
      int i;
      host.slow = 1'b1;
      host.send(8'h58);
      cyc(1);
      chk("mode", 1'b1, matrix_mode);
      req(1'b0, 18);
      for (i = 0; i < 9; i++)
      begin
         chk("lo", {i == 0, mat[136 - 16 * i -: 7]}, host.got[2 * i]);
         chk("hi", {1'b0, mat[143 - 16 * i -: 7]}, host.got[2 * i + 1]);
      end
      host.slow = 1'b0;
   endtask
   task t_score;
      button_mode = 1'b1;
      cmd3(8'h73, 8'h01, 8'h00);
      cyc(1);
      chk("dist", 1'b1, dist_enable);
      cmd3(8'h73, 8'h05, 8'h7F);
      score(8'h02, 8'h01, 8'h32);
      score(8'h03, 8'h0A, 8'h28);
      rng = 16'h0005;
      score(8'h04, 8'h01, 8'h23);
      score(8'h02, 8'h7F, 8'h7F);
      raw = 16'hFFF0;
      score(8'h02, 8'h01, 8'h00);
      cmd3(8'h73, 8'h06, 8'h00);
      cyc(1);
      chk("dist", 1'b1, dist_enable);
      host.send(8'h73);
      host.send(8'h00);
      cyc(1);
      chk("dist", 1'b1, dist_enable);
      host.send(8'h00);
      cyc(1);
      chk("dist", 1'b0, dist_enable);
      host.send(8'h58);
      btn = 8'h3C;
      req(1'b0, 19);
      chk("btn", btn, host.got[18]);
   endtask
   task t_offset;
      int i;
      logic [7:0] ob [6];
      ob = '{8'h33, 8'h13, 8'h89, 8'hF8, 8'h9F, 8'h04};
      px = 16'h0100;
      py = 16'h8000;
      pz = 16'h7FF0;
      oy = 16'hFFFF;
      oz = 16'h0020;
      host.send(8'h4B);
      for (i = 0; i < 5; i++)
         host.send(ob[i]);
      cyc(1);
      chk("offz", 16'h0000, offset_z);
      host.send(ob[5]);
      cyc(1);
      chk("offx", 16'h1333, offset_x);
      chk("offy", 16'hF889, offset_y);
      chk("offz", 16'h049F, offset_z);
      chk("posx", 16'h1433, pos_x);
      chk("posy", 16'h7FFF, pos_y);
      chk("posz", 16'h8010, pos_z);
      req(1'b1, 6);
      for (i = 0; i < 6; i++)
         chk("rd", ob[i], host.got[i]);
      host.send(8'h42);
      cyc(1);
      chk("mode", 1'b0, matrix_mode);
   endtask
   initial
   begin
      cyc(16);
      rst_b = 1'b1;
      cyc(1);
      chk("mode", 1'b0, matrix_mode);
      chk("dist", 1'b0, dist_enable);
      t_matrix();
      t_score();
      t_offset();
      test_done();
   end
endmodule // tb_tracker_matrix_metal_offset_cmds
bind tmmo_cmd tmmo_checker tmmo_chk (.mclk, .rst_b, .rx_valid, .rx_byte, .record_req,
   .offset_read_req, .button_mode, .tx_ready, .pos_x_in, .rot_off_x, .tx_valid,
   .tx_byte, .matrix_mode, .dist_enable, .busy, .offset_z, .pos_x);
`default_nettype wire
